// file: rtl/sasl_defines.svh
`ifndef SASL_DEFINES_SVH
`define SASL_DEFINES_SVH

// ****************************************************************
// Word layout
// ****************************************************************
`define SASL_CODE_W 5
`define SASL_WORD_W 6
`define SASL_LEAD_POS 5
`define SASL_EIGHT_POS 4
`define SASL_FOUR_POS 3
`define SASL_TWO_POS 2
`define SASL_ONE_POS 1
`define SASL_HALF_POS 0

// ****************************************************************
// Reset values
// ****************************************************************
`define SASL_CODE_RST 5'h00
`define SASL_WORD_RST 6'h00
`define SASL_CNT_RST 3'h0

// ****************************************************************
// Timing
// ****************************************************************
`define SASL_SYS_CLK_MHZ 100
`define SASL_SETTLE_NS 1000
`define SASL_SETTLE_CYC ((`SASL_SETTLE_NS * `SASL_SYS_CLK_MHZ + 999) / 1000)
`define SASL_SYNC_STAGES 3
`define SASL_LINK_RST_STAGES 2

`endif

// file: rtl/sasl_pkg.sv
package sasl_pkg;

    // Attenuation code in half-decibel steps
    typedef logic [4:0] sasl_code_t;

    // Raw shifted word, lead bit on top
    typedef logic [5:0] sasl_word_t;

    // Output latch behaviour
    typedef enum logic {
        SASL_LATCH_HELD,
        SASL_LATCH_OPEN
    } sasl_latch_e;

endpackage

// file: rtl/sasl_sync.sv
`timescale 1ns/1ps

module sasl_sync #(
    parameter int STAGES = 3,
    parameter logic RST_VAL = 1'b0
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic din,
    output logic dout
);

    // ************************************************************
    // State
    // ************************************************************
    typedef struct packed {
        logic [STAGES-1:0] chain;
        logic stable;
    } sasl_sync_s;

    sasl_sync_s st_r;
    sasl_sync_s st_nxt;

    generate
        if (STAGES < 3) begin : g_bad
            $error("sasl_sync needs at least three stages");
        end
    endgenerate

    // ************************************************************
    // Chain and agreement filter
    // ************************************************************
    always_comb begin
        st_nxt = st_r;
        st_nxt.chain = {st_r.chain[STAGES-2:0], din};
        // Change counts once the last two stages agree
        if (st_r.chain[STAGES-1] == st_r.chain[STAGES-2]) begin
            st_nxt.stable = st_r.chain[STAGES-1];
        end
        if (!nrst) begin
            st_nxt.chain = {STAGES{RST_VAL}};
            st_nxt.stable = RST_VAL;
        end
    end

    always_ff @(posedge clk) begin
        st_r <= st_nxt;
    end

    assign dout = st_r.stable;

endmodule

// file: rtl/sasl_link_shift.sv
`timescale 1ns/1ps
`include "sasl_defines.svh"

module sasl_link_shift (
    input wire logic serial_clk,
    input wire logic nrst,
    input wire logic serial_data,
    output sasl_pkg::sasl_word_t link_word,
    output logic link_toggle
);

    // ************************************************************
    // State
    // ************************************************************
    typedef struct packed {
        logic [`SASL_LINK_RST_STAGES-1:0] rst_chain;
        sasl_pkg::sasl_word_t shreg;
        logic toggle;
    } sasl_link_s;

    sasl_link_s st_r;
    sasl_link_s st_nxt;

    // ************************************************************
    // Shift on every rising serial edge, whatever the strobe does
    // ************************************************************
    always_comb begin
        st_nxt = st_r;
        st_nxt.rst_chain = {st_r.rst_chain[`SASL_LINK_RST_STAGES-2:0], nrst};
        // Oldest bit falls off the top, newest enters bit 0
        st_nxt.shreg = {st_r.shreg[`SASL_WORD_W-2:0], serial_data};
        // One toggle per shifted bit tells the system side
        st_nxt.toggle = ~st_r.toggle;
        if (!st_r.rst_chain[`SASL_LINK_RST_STAGES-1]) begin
            st_nxt.shreg = `SASL_WORD_RST;
            st_nxt.toggle = 1'b0;
        end
    end

    always_ff @(posedge serial_clk) begin
        st_r <= st_nxt;
    end

    assign link_word = st_r.shreg;
    assign link_toggle = st_r.toggle;

endmodule

// file: rtl/sasl_top.sv
`timescale 1ns/1ps
`include "sasl_defines.svh"

// Functional notes
// - Attenuation follows exactly five control bits behind the serial port.
// - All 32 codes valid; weights 8,4,2,1,0.5 dB; code counts half-dB.
// - Six-bit shift register feeds a transparent latch; last five control.
// - Data shifts in on every rising serial clock edge.
// - Shifting continues whatever the hold strobe level.
// - Strobe high: latch transparent, shift contents drive attenuation.
// - Strobe falling: contents captured and held until strobe rises.
// - After a change, settling flagged for about one microsecond.
module sasl_top #(
    parameter int SETTLE_CYC = `SASL_SETTLE_CYC,
    parameter int SYNC_STAGES = `SASL_SYNC_STAGES
) (
    input wire logic sys_clk,
    input wire logic nrst,
    input wire logic serial_clk,
    input wire logic serial_data,
    input wire logic hold_strobe,
    output sasl_pkg::sasl_code_t atten_code,
    output logic eight_db_bit,
    output logic four_db_bit,
    output logic two_db_bit,
    output logic one_db_bit,
    output logic half_db_bit,
    output logic reference_state,
    output logic latch_open,
    output logic code_applied,
    output logic settling,
    output logic lead_bit_error,
    output logic short_word,
    output logic long_word,
    output logic entry_while_open,
    output logic word_pending
);

    // ************************************************************
    // Parameter checks
    // ************************************************************
    localparam int CNT_W = $clog2(SETTLE_CYC + 1);
    localparam int WARM_CYC = SYNC_STAGES + 2;
    localparam int WARM_W = $clog2(WARM_CYC + 1);
    localparam logic [2:0] WORD_BITS = 3'(`SASL_WORD_W);
    localparam logic [2:0] CNT_MAX = 3'h7;

    generate
        if (SETTLE_CYC < 1) begin : g_bad_settle
            $error("sasl_top settle count must be at least one");
        end
        if (SYNC_STAGES < 3) begin : g_bad_sync
            $error("sasl_top needs at least three sync stages");
        end
        if (`SASL_WORD_W != `SASL_CODE_W + 1) begin : g_bad_word
            $error("sasl_top word must be one lead bit plus the code");
        end
        if (`SASL_WORD_W >= 7) begin : g_bad_cnt
            $error("sasl_top bit counter cannot flag a long word");
        end
    endgenerate

    // ************************************************************
    // State
    // ************************************************************
    typedef struct packed {
        sasl_pkg::sasl_latch_e mode;
        logic strobe_d;
        logic toggle_d;
        logic [WARM_W-1:0] warm;
        sasl_pkg::sasl_word_t word_copy;
        sasl_pkg::sasl_code_t code;
        logic [2:0] bit_cnt;
        logic [CNT_W-1:0] settle_cnt;
        logic eight;
        logic four;
        logic two;
        logic one;
        logic half;
        logic reference;
        logic open;
        logic applied;
        logic busy;
        logic lead_err;
        logic short_w;
        logic long_w;
        logic entry_open;
        logic pending;
    } sasl_core_s;

    localparam sasl_core_s CORE_RST = '{
        mode: sasl_pkg::SASL_LATCH_HELD,
        strobe_d: 1'b0,
        toggle_d: 1'b0,
        warm: '0,
        word_copy: `SASL_WORD_RST,
        code: `SASL_CODE_RST,
        bit_cnt: `SASL_CNT_RST,
        settle_cnt: '0,
        eight: 1'b0,
        four: 1'b0,
        two: 1'b0,
        one: 1'b0,
        half: 1'b0,
        reference: 1'b1,
        open: 1'b0,
        applied: 1'b0,
        busy: 1'b0,
        lead_err: 1'b0,
        short_w: 1'b0,
        long_w: 1'b0,
        entry_open: 1'b0,
        pending: 1'b0
    };

    sasl_core_s st_r;
    sasl_core_s st_nxt;

    sasl_pkg::sasl_word_t link_word;
    logic link_toggle;
    logic strobe_s;
    logic toggle_s;
    logic strobe_rise;
    logic strobe_fall;
    logic bit_evt;

    // ************************************************************
    // Serial clock domain
    // ************************************************************
    sasl_link_shift u_link (
        .serial_clk(serial_clk),
        .nrst(nrst),
        .serial_data(serial_data),
        .link_word(link_word),
        .link_toggle(link_toggle)
    );

    // ************************************************************
    // Crossings into the system clock
    // ************************************************************
    sasl_sync #(
        .STAGES(SYNC_STAGES),
        .RST_VAL(1'b0)
    ) u_strobe_sync (
        .clk(sys_clk),
        .nrst(nrst),
        .din(hold_strobe),
        .dout(strobe_s)
    );

    // Word is stable a full serial period after each toggle
    sasl_sync #(
        .STAGES(SYNC_STAGES),
        .RST_VAL(1'b0)
    ) u_toggle_sync (
        .clk(sys_clk),
        .nrst(nrst),
        .din(link_toggle),
        .dout(toggle_s)
    );

    // ************************************************************
    // Latch, settle timer and word checks
    // ************************************************************
    always_comb begin
        st_nxt = st_r;

        // ********************************************************
        // Edges of the synchronised strobe and bit toggle
        // ********************************************************
        strobe_rise = strobe_s & ~st_r.strobe_d;
        strobe_fall = ~strobe_s & st_r.strobe_d;
        bit_evt = toggle_s ^ st_r.toggle_d;
        st_nxt.strobe_d = strobe_s;
        st_nxt.toggle_d = toggle_s;
        st_nxt.applied = 1'b0;

        // Toggle level after reset is unknown until the chain refills
        if (st_r.warm != WARM_W'(WARM_CYC)) begin
            st_nxt.warm = st_r.warm + WARM_W'(1);
            bit_evt = 1'b0;
        end

        // ********************************************************
        // Word tracking
        // ********************************************************
        // Fresh copy of the shift register after each shifted bit
        if (bit_evt) begin
            st_nxt.word_copy = link_word;
        end

        // ********************************************************
        // Word length checks
        // ********************************************************
        // Bits since the last capture; a bit in the fall cycle counts
        if (strobe_fall) begin
            st_nxt.bit_cnt = bit_evt ? 3'h1 : 3'h0;
        end else if (bit_evt && st_r.bit_cnt != CNT_MAX) begin
            st_nxt.bit_cnt = st_r.bit_cnt + 3'h1;
        end

        // Word length judged as the strobe opens the latch
        if (strobe_rise) begin
            st_nxt.short_w = st_nxt.bit_cnt < WORD_BITS;
            st_nxt.long_w = st_nxt.bit_cnt > WORD_BITS;
        end

        // Shifting while transparent changes the output mid-entry
        if (strobe_rise) begin
            st_nxt.entry_open = 1'b0;
        end
        if (bit_evt && strobe_s && !strobe_rise) begin
            st_nxt.entry_open = 1'b1;
        end

        // ********************************************************
        // Latch
        // ********************************************************
        // Transparent while high, captured on the falling strobe
        case (st_r.mode)
            sasl_pkg::SASL_LATCH_HELD: begin
                if (strobe_s) begin
                    st_nxt.mode = sasl_pkg::SASL_LATCH_OPEN;
                    st_nxt.code = st_nxt.word_copy[`SASL_CODE_W-1:0];
                    st_nxt.lead_err = st_nxt.word_copy[`SASL_LEAD_POS];
                end
            end
            sasl_pkg::SASL_LATCH_OPEN: begin
                // Last update on the fall cycle, then the code holds
                st_nxt.code = st_nxt.word_copy[`SASL_CODE_W-1:0];
                st_nxt.lead_err = st_nxt.word_copy[`SASL_LEAD_POS];
                if (!strobe_s) begin
                    st_nxt.mode = sasl_pkg::SASL_LATCH_HELD;
                end
            end
            default: begin
                st_nxt.mode = sasl_pkg::SASL_LATCH_HELD;
            end
        endcase

        // Bits waiting in the register, not yet applied
        st_nxt.pending = (st_nxt.bit_cnt != 3'h0) &&
            (st_nxt.mode == sasl_pkg::SASL_LATCH_HELD);

        // ********************************************************
        // Settle timer
        // ********************************************************
        // Settle window restarts on every code change
        if (st_nxt.code != st_r.code) begin
            st_nxt.settle_cnt = CNT_W'(SETTLE_CYC);
            st_nxt.applied = 1'b1;
        end else if (st_r.settle_cnt != '0) begin
            st_nxt.settle_cnt = st_r.settle_cnt - CNT_W'(1);
        end
        st_nxt.busy = st_nxt.settle_cnt != '0;

        // ********************************************************
        // Attenuator drive
        // ********************************************************
        // Binary weights: code value is attenuation in half-dB
        st_nxt.eight = st_nxt.code[`SASL_EIGHT_POS];
        st_nxt.four = st_nxt.code[`SASL_FOUR_POS];
        st_nxt.two = st_nxt.code[`SASL_TWO_POS];
        st_nxt.one = st_nxt.code[`SASL_ONE_POS];
        st_nxt.half = st_nxt.code[`SASL_HALF_POS];
        st_nxt.reference = st_nxt.code == `SASL_CODE_RST;
        st_nxt.open = st_nxt.mode == sasl_pkg::SASL_LATCH_OPEN;

        // ********************************************************
        // Reset
        // ********************************************************
        if (!nrst) begin
            st_nxt = CORE_RST;
        end
    end

    always_ff @(posedge sys_clk) begin
        st_r <= st_nxt;
    end

    // ************************************************************
    // Outputs
    // ************************************************************
    assign atten_code = st_r.code;
    assign eight_db_bit = st_r.eight;
    assign four_db_bit = st_r.four;
    assign two_db_bit = st_r.two;
    assign one_db_bit = st_r.one;
    assign half_db_bit = st_r.half;
    assign reference_state = st_r.reference;
    assign latch_open = st_r.open;
    assign code_applied = st_r.applied;
    assign settling = st_r.busy;
    assign lead_bit_error = st_r.lead_err;
    assign short_word = st_r.short_w;
    assign long_word = st_r.long_w;
    assign entry_while_open = st_r.entry_open;
    assign word_pending = st_r.pending;

endmodule

// file: testbench/sasl_ctrl_model.sv
`timescale 1ns/1ps

module sasl_ctrl_model (
    output logic serial_clk,
    output logic serial_data,
    output logic hold_strobe
);
    // Phase of six 10 ns system periods leaves time for the word copy
    localparam int HALF = 60;
    initial begin
        serial_clk = 1'b0;
        serial_data = 1'b1;
        hold_strobe = 1'b0;
    end
    // ****************
    // Word entry
    // ****************
    task automatic shift_bits(input int n, input logic [7:0] w);
        #7.3;
        for (int i = n - 1; i >= 0; i--) begin
            serial_data = w[i];
            #HALF serial_clk = 1'b1;
            #HALF serial_clk = 1'b0;
            if (i == 0) begin
                serial_data = ~w[i];
            end
        end
    endtask
    task automatic pulse_strobe();
        #20 hold_strobe = 1'b1;
        #HALF hold_strobe = 1'b0;
    endtask
    task automatic set_strobe(input logic v);
        hold_strobe = v;
    endtask
endmodule

// file: testbench/sasl_top_asserts.sv
`timescale 1ns/1ps

module sasl_top_asserts #(
    parameter int SETTLE_CYC = 4
) (
    input wire logic sys_clk,
    input wire logic nrst,
    input wire logic hold_strobe,
    input wire sasl_pkg::sasl_code_t atten_code,
    input wire logic eight_db_bit,
    input wire logic four_db_bit,
    input wire logic two_db_bit,
    input wire logic one_db_bit,
    input wire logic half_db_bit,
    input wire logic reference_state,
    input wire logic latch_open,
    input wire logic code_applied,
    input wire logic settling,
    input wire logic word_pending
);
    int since_r;
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!nrst);
    // Cycles since last code change, saturating
    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            since_r <= SETTLE_CYC;
        end else if (code_applied) begin
            since_r <= 1;
        end else if (since_r < SETTLE_CYC) begin
            since_r <= since_r + 1;
        end
    end
    property p_bits;
        atten_code == {eight_db_bit, four_db_bit, two_db_bit, one_db_bit,
            half_db_bit};
    endproperty
    a_bits: assert property (p_bits) else $error("bits differ");
    property p_ref;
        reference_state == (atten_code == 5'h00);
    endproperty
    a_ref: assert property (p_ref) else $error("reference wrong");
    property p_held;
        !latch_open && !$past(latch_open) |-> $stable(atten_code);
    endproperty
    a_held: assert property (p_held) else $error("held code moved");
    property p_applied;
        code_applied == $changed(atten_code);
    endproperty
    a_applied: assert property (p_applied) else $error("pulse wrong");
    property p_settle;
        settling == (code_applied || since_r < SETTLE_CYC);
    endproperty
    a_settle: assert property (p_settle) else $error("settle wrong");
    property p_open;
        $rose(hold_strobe) |-> ##[1:6] latch_open;
    endproperty
    a_open: assert property (p_open) else $error("latch not open");
    property p_close;
        $fell(hold_strobe) |-> ##[1:6] !latch_open;
    endproperty
    a_close: assert property (p_close) else $error("latch not shut");
    property p_shut;
        !hold_strobe [*6] |-> !latch_open;
    endproperty
    a_shut: assert property (p_shut) else $error("open while low");
    property p_pending;
        word_pending && $past(word_pending) |-> $stable(atten_code);
    endproperty
    a_pending: assert property (p_pending) else $error("pending");
endmodule

bind sasl_top sasl_top_asserts #(.SETTLE_CYC(SETTLE_CYC)) u_asserts (
    .sys_clk(sys_clk),
    .nrst(nrst),
    .hold_strobe(hold_strobe),
    .atten_code(atten_code),
    .eight_db_bit(eight_db_bit),
    .four_db_bit(four_db_bit),
    .two_db_bit(two_db_bit),
    .one_db_bit(one_db_bit),
    .half_db_bit(half_db_bit),
    .reference_state(reference_state),
    .latch_open(latch_open),
    .code_applied(code_applied),
    .settling(settling),
    .word_pending(word_pending)
);

// file: testbench/step_attenuator_serial_latch_tb.sv
`timescale 1ns/1ps

module step_attenuator_serial_latch_tb;
    logic sys_clk = 1'b0;
    logic nrst = 1'b0;
    logic serial_clk, serial_data, hold_strobe;
    sasl_pkg::sasl_code_t atten_code;
    logic eight_db_bit, four_db_bit, two_db_bit, one_db_bit, half_db_bit;
    logic reference_state, latch_open, code_applied, settling;
    logic lead_bit_error, short_word, long_word, entry_while_open;
    logic word_pending;
    int err_total = 0;
    int samples_checked = 0;
    int bitq[$];
    int exp_code = 0;
    int exp_lead = 0;
    int exp_entry = 0;
    int exp_pend = 0;
    int strobe_hi = 0;
    always #5 sys_clk = ~sys_clk;
    sasl_ctrl_model ctrl (
        .serial_clk(serial_clk),
        .serial_data(serial_data),
        .hold_strobe(hold_strobe)
    );
    sasl_top #(.SETTLE_CYC(4), .SYNC_STAGES(3)) dut (
        .sys_clk(sys_clk),
        .nrst(nrst),
        .serial_clk(serial_clk),
        .serial_data(serial_data),
        .hold_strobe(hold_strobe),
        .atten_code(atten_code),
        .eight_db_bit(eight_db_bit),
        .four_db_bit(four_db_bit),
        .two_db_bit(two_db_bit),
        .one_db_bit(one_db_bit),
        .half_db_bit(half_db_bit),
        .reference_state(reference_state),
        .latch_open(latch_open),
        .code_applied(code_applied),
        .settling(settling),
        .lead_bit_error(lead_bit_error),
        .short_word(short_word),
        .long_word(long_word),
        .entry_while_open(entry_while_open),
        .word_pending(word_pending)
    );
    // ****************
    // Compare and model
    // ****************
    task automatic chk_code(string what, sasl_pkg::sasl_code_t s, int e);
        samples_checked++;
        if (s !== 5'(e)) begin
            err_total++;
            $display("[FAIL] %s expected %0d seen %0d", what, e, s);
        end
    endtask
    task automatic chk_flag(string what, logic s, int e);
        samples_checked++;
        if (s !== 1'(e)) begin
            err_total++;
            $display("[FAIL] %s expected %0d seen %b", what, e, s);
        end
    endtask
    task automatic check_all(int s, int l);
        chk_code("atten_code", atten_code, exp_code);
        chk_code("db_bits", {eight_db_bit, four_db_bit, two_db_bit,
            one_db_bit, half_db_bit}, exp_code);
        chk_flag("reference_state", reference_state, exp_code == 0);
        chk_flag("lead_bit_error", lead_bit_error, exp_lead);
        chk_flag("short_word", short_word, s);
        chk_flag("long_word", long_word, l);
        chk_flag("entry_while_open", entry_while_open, exp_entry);
        chk_flag("word_pending", word_pending, exp_pend);
        chk_flag("settling", settling, 0);
        chk_flag("code_applied", code_applied, 0);
    endtask
    task automatic update_exp();
        exp_code = 0;
        for (int i = 5; i >= 1; i--) begin
            exp_code = exp_code * 2 + bitq[bitq.size() - i];
        end
        exp_lead = bitq[bitq.size() - 6];
    endtask
    task automatic send(int n, logic [7:0] w);
        for (int i = n - 1; i >= 0; i--) begin
            bitq.push_back(int'(w[i]));
        end
        if (strobe_hi != 0) begin
            exp_entry = 1;
        end else begin
            exp_pend = 1;
        end
        ctrl.shift_bits(n, w);
        repeat (8) @(negedge sys_clk);
    endtask
    task automatic latch_now();
        ctrl.pulse_strobe();
        update_exp();
        exp_entry = 0;
        exp_pend = 0;
        repeat (8) @(negedge sys_clk);
    endtask
    task automatic strobe_level(input logic v);
        ctrl.set_strobe(v);
        strobe_hi = int'(v);
        if (v) begin
            exp_entry = 0;
        end else begin
            exp_pend = 0;
        end
    endtask
    task automatic end_of_test();
        if (err_total == 0 && samples_checked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    initial begin
        #150us;
        err_total++;
        end_of_test();
    end
    initial begin
        int r;
        for (int i = 0; i < 6; i++) begin
            bitq.push_back(0);
        end
        r = $urandom(88050);
        r = $urandom_range(31);
        @(negedge sys_clk);
        ctrl.shift_bits(4, 8'h00);
        @(negedge sys_clk);
        nrst = 1'b1;
        ctrl.shift_bits(2, 8'h00);
        for (int c = 0; c < 32; c++) begin
            send(6, 8'(c ^ r));
            latch_now();
            check_all(0, 0);
            chk_flag("latch_open", latch_open, 0);
        end
        repeat (8) begin
            send(6, 8'($urandom_range(63)));
            latch_now();
            check_all(0, 0);
        end
        // Entry with the latch transparent
        strobe_level(1'b1);
        repeat (8) @(negedge sys_clk);
        send(6, 8'($urandom_range(31)));
        update_exp();
        check_all(1, 0);
        chk_flag("latch_open", latch_open, 1);
        chk_flag("entry_while_open", entry_while_open, 1);
        strobe_level(1'b0);
        repeat (8) @(negedge sys_clk);
        // New word with strobe low stays off the attenuator
        send(6, 8'(exp_code ^ 31));
        check_all(1, 0);
        chk_flag("word_pending", word_pending, 1);
        latch_now();
        check_all(0, 0);
        send(4, 8'($urandom_range(15)));
        latch_now();
        check_all(1, 0);
        send(8, 8'($urandom_range(255)));
        latch_now();
        check_all(0, 1);
        end_of_test();
    end
endmodule
